// ==== rtl/cpu_bus_pins.v ====
// Purpose: External bus and control pin sequencer of an 8-bit processor.
// Assumes: Core issues one request per machine cycle; pins are async inputs.
// Notes: Machine cycle is T1,T2,Tw*,T3 on phi; halves are mclk cycles.
`timescale 1ns/1ps
`include "cpu_pins_map.vh"
module cpu_bus_pins #(
	parameter AW = `ADDR_W,
	parameter DW = `DATA_W
) (
	input  wire          mclk,
	input  wire          nrst,
	// Core side
	input  wire [2:0]    req_kind,
	input  wire [AW-1:0] req_addr,
	input  wire [DW-1:0] req_wdata,
	input  wire          req_first_fetch,
	input  wire          req_last_dma_ch0,
	input  wire          req_last_dma_ch1,
	input  wire          req_instr_end,
	input  wire          req_halt,
	input  wire          req_sleep,
	input  wire          timer_wave_out,
	input  wire          timer_pin_sel,
	input  wire [1:0]    dma_edge_mode,
	output wire          req_ready,
	output reg           cycle_done,
	output reg  [DW-1:0] read_data,
	output reg  [2:0]    irq_take,
	output reg  [AW-1:0] irq_vector_addr,
	output wire [1:0]    dma_pending,
	input  wire [1:0]    dma_taken,
	output wire          bus_granted,
	// Pins
	output wire          sys_clk,
	output wire [AW-1:0] addr_o,
	output wire [AW-1:0] addr_oe,
	input  wire [DW-1:0] data_i,
	output wire [DW-1:0] data_o,
	output wire          data_oe,
	output wire          memory_cycle_n,
	output wire          io_cycle_n,
	output wire          read_pulse_n,
	output wire          put_pulse_n,
	output wire          strobe_oe,
	output wire          fetch_mark_n,
	output wire          refresh_cycle_n,
	output wire          cycle_kind_flag,
	output wire          idle_wait_n,
	output wire          bus_grant_n,
	output wire          block_done_0_n,
	output wire          block_done_1_n,
	input  wire          wait_n,
	input  wire          bus_claim_n,
	input  wire          nonmaskable_irq_n,
	input  wire          maskable_irq_0_n,
	input  wire          maskable_irq_1_n,
	input  wire          maskable_irq_2_n,
	input  wire [1:0]    dma_req_n
);
	localparam S_IDLE  = 3'h0;
	localparam S_T1    = 3'h1;
	localparam S_T2    = 3'h2;
	localparam S_TW    = 3'h3;
	localparam S_T3    = 3'h4;
	localparam S_GRANT = 3'h5;
	localparam S_STOP  = 3'h6;

	reg  [2:0]    state_q;
	reg  [2:0]    kind_q;
	reg  [AW-1:0] addr_q;
	reg  [DW-1:0] wdata_q;
	reg           first_q;
	reg  [1:0]    last_q;
	reg           inta0_q;
	reg           ack0_pend_q;
	reg           sleep_q;
	reg           phi_q;
	reg           nmi_pend_q;
	reg  [1:0]    dreq_edge_q;
	reg  [2:0]    st_q;
	reg           reset_done_q;

	wire [7:0]    sync_lvl;
	wire [7:0]    sync_fall;
	wire          wait_s, claim_s, irq0_s, irq1_s, irq2_s;
	wire          rise;
	wire          in_cycle;
	wire          drive_bus;
	wire          is_io, is_mem, is_rd, is_wr;

	// All pin inputs except data_i pass two flops before use
	sync_edge #(.W(8)) u_sync (
		.mclk       (mclk),
		.nrst       (nrst),
		.async_in   ({dma_req_n, maskable_irq_2_n, maskable_irq_1_n, maskable_irq_0_n,
			nonmaskable_irq_n, bus_claim_n, wait_n}),
		.rst_val    (8'hff),
		.level_out  (sync_lvl),
		.fall_pulse (sync_fall)
	);
	assign wait_s  = sync_lvl[0];
	assign claim_s = sync_lvl[1];
	assign irq0_s  = sync_lvl[3];
	assign irq1_s  = sync_lvl[4];
	assign irq2_s  = sync_lvl[5];

	// Phase toggles every mclk; rise marks start of each phi period
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			phi_q        <= 1'b0;
			reset_done_q <= 1'b0;
		end else begin
			phi_q        <= ~phi_q;
			reset_done_q <= 1'b1;
		end
	end
	assign sys_clk = phi_q;
	assign rise    = ~phi_q;

	// NMI edge is latched until taken at an instruction end
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			nmi_pend_q <= 1'b0;
		end else if (sync_fall[2]) begin
			nmi_pend_q <= 1'b1;
		end else if (irq_take == `TAKE_NMI) begin
			nmi_pend_q <= 1'b0;
		end
	end

	// DMA request: edge mode latches, level mode follows pin; new edge beats take
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dreq_edge_q <= 2'h0;
		end else begin
			dreq_edge_q <= (dreq_edge_q & ~dma_taken) | sync_fall[7:6];
		end
	end
	assign dma_pending = (dma_edge_mode & dreq_edge_q) | (~dma_edge_mode & ~sync_lvl[7:6]);

	// Interrupt priority: NMI, then MASKABLE_IRQ_0_N, MASKABLE_IRQ_1_N, MASKABLE_IRQ_2_N; claim blocks all
	always @* begin
		irq_take        = `TAKE_NONE;
		irq_vector_addr = {AW{1'b0}};
		if (cycle_done && req_instr_end && claim_s) begin
			if (nmi_pend_q) begin
				irq_take        = `TAKE_NMI;
				irq_vector_addr = `NMI_VECTOR;
			end else if (!irq0_s) begin
				irq_take = `TAKE_MASKABLE_IRQ_0_N;
			end else if (!irq1_s) begin
				irq_take = `TAKE_MASKABLE_IRQ_1_N;
			end else if (!irq2_s) begin
				irq_take = `TAKE_MASKABLE_IRQ_2_N;
			end
		end
	end

	assign in_cycle  = (state_q == S_T1) || (state_q == S_T2) || (state_q == S_TW) || (state_q == S_T3);
	assign req_ready = rise && claim_s && reset_done_q && (state_q == S_IDLE || state_q == S_T3);
	assign bus_granted = (state_q == S_GRANT);

	// Machine cycle sequencer advancing on phi rising edges
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q    <= S_IDLE;
			kind_q     <= `REQ_NONE;
			addr_q     <= {AW{1'b0}};
			wdata_q    <= {DW{1'b0}};
			first_q    <= 1'b0;
			last_q     <= 2'h0;
			inta0_q    <= 1'b0;
			ack0_pend_q <= 1'b0;
			sleep_q    <= 1'b0;
			cycle_done <= 1'b0;
			read_data  <= {DW{1'b0}};
		end else begin
			cycle_done <= 1'b0;
			// Take code stands only in the phi-high half, so hold it for the next request
			if (irq_take == `TAKE_MASKABLE_IRQ_0_N) begin
				ack0_pend_q <= 1'b1;
			end
			if (rise) begin
				case (state_q)
				S_IDLE, S_T3: begin
					if (state_q == S_T3) begin
						cycle_done <= 1'b1;
					end
					if (!claim_s) begin
						state_q <= S_GRANT;
					end else if (req_halt || req_sleep) begin
						state_q <= S_STOP;
						sleep_q <= req_sleep;
					end else if (req_kind != `REQ_NONE) begin
						state_q <= S_T1;
						kind_q  <= req_kind;
						addr_q  <= (req_kind == `REQ_IO_RD || req_kind == `REQ_IO_WR) ?
							{{(AW-`IO_ADDR_W){1'b0}}, req_addr[`IO_ADDR_W-1:0]} :
							(req_kind == `REQ_REFRESH) ?
							{{(AW-`REFRESH_CYCLE_N_W){1'b0}}, req_addr[`REFRESH_CYCLE_N_W-1:0]} :
							req_addr;
						wdata_q <= req_wdata;
						first_q <= req_first_fetch;
						last_q  <= {req_last_dma_ch1, req_last_dma_ch0};
						inta0_q <= ack0_pend_q;
						ack0_pend_q <= 1'b0;
					end else begin
						state_q <= S_IDLE;
					end
				end
				S_T1: state_q <= S_T2;
				S_T2, S_TW: begin
					// Wait sampled mid-T2 and each Tw, taken here at the next rise
					state_q <= wait_s ? S_T3 : S_TW;
				end
				S_GRANT: begin
					if (claim_s) begin
						state_q <= S_IDLE;
					end
				end
				S_STOP: begin
					if (nmi_pend_q || !irq0_s || !irq1_s || !irq2_s || !claim_s) begin
						state_q <= S_IDLE;
						sleep_q <= 1'b0;
					end
				end
				default: state_q <= S_IDLE;
				endcase
			end
			// Read data captured while read strobe is low, at the end of the phi-high first half of T3
			if (!rise && state_q == S_T3 && is_rd) begin
				read_data <= data_i;
			end
		end
	end

	assign is_io  = (kind_q == `REQ_IO_RD) || (kind_q == `REQ_IO_WR) || inta0_q;
	assign is_mem = (kind_q == `REQ_FETCH) || (kind_q == `REQ_MEM_RD) || (kind_q == `REQ_MEM_WR)
		|| (kind_q == `REQ_REFRESH) || (kind_q == `REQ_DMA);
	assign is_rd  = !inta0_q && ((kind_q == `REQ_FETCH) || (kind_q == `REQ_MEM_RD) || (kind_q == `REQ_IO_RD));
	assign is_wr  = !inta0_q && ((kind_q == `REQ_MEM_WR) || (kind_q == `REQ_IO_WR) || (kind_q == `REQ_DMA));

	// Buses float in reset and grant; halt and sleep drive the address all high, idle keeps the last address
	assign drive_bus = reset_done_q && (state_q != S_GRANT);
	assign addr_o    = (state_q == S_STOP) ? {AW{1'b1}} :
		{addr_q[AW-1:19], (timer_pin_sel ? timer_wave_out : addr_q[18]), addr_q[17:0]};
	assign addr_oe   = {AW{drive_bus}};
	assign data_o    = wdata_q;
	assign data_oe   = drive_bus && in_cycle && (state_q != S_T1) && is_wr;

	// Strobes high outside cycles except fetch_mark_n low in halt, floated only while granted
	assign strobe_oe      = (state_q != S_GRANT);
	assign memory_cycle_n = !(in_cycle && is_mem && !inta0_q);
	assign io_cycle_n     = !(in_cycle && is_io);
	assign read_pulse_n   = !(in_cycle && (state_q != S_T1) && is_rd);
	assign put_pulse_n    = !(data_oe && (state_q != S_T2 || !rise));
	// Halt status code needs the fetch mark low as well
	assign fetch_mark_n   = !((in_cycle && ((kind_q == `REQ_FETCH) || inta0_q)) ||
		(state_q == S_STOP && !sleep_q));
	assign refresh_cycle_n = !(in_cycle && kind_q == `REQ_REFRESH);
	assign block_done_0_n = !(in_cycle && kind_q == `REQ_DMA && last_q[0]);
	assign block_done_1_n = !(in_cycle && kind_q == `REQ_DMA && last_q[1]);
	assign bus_grant_n    = !(state_q == S_GRANT) || !reset_done_q;

	// Status encoding decoded combinationally per machine state
	always @* begin
		if (!reset_done_q) begin
			st_q = `ST_OTHER;
		end else if (state_q == S_STOP) begin
			st_q = sleep_q ? `ST_SLEEP : `ST_HALT;
		end else if (state_q == S_GRANT) begin
			st_q = `ST_OTHER;
		end else if (in_cycle && kind_q == `REQ_DMA) begin
			st_q = `ST_DMA;
		end else if (in_cycle && kind_q == `REQ_FETCH) begin
			st_q = first_q ? `ST_FIRST_FETCH : `ST_NEXT_FETCH;
		end else begin
			st_q = `ST_OTHER;
		end
	end
	assign cycle_kind_flag = st_q[2];
	assign idle_wait_n     = st_q[1];
endmodule // cpu_bus_pins

// ==== common/cpu_pins_map.vh ====
// Purpose: Constants for the external bus pin controller.
// Assumes: Included by bare name from rtl files.
// Notes: Timing counts are in mclk cycles.
`ifndef CPU_PINS_MAP_VH
`define CPU_PINS_MAP_VH
`define ADDR_W        20
`define DATA_W        8
`define IO_ADDR_W     16
`define REFRESH_CYCLE_N_W        8
`define NMI_VECTOR    20'h00066
`define CLK_DIV_HALF  1'b1
// Request codes from the core side
`define REQ_NONE      3'h0
`define REQ_FETCH     3'h1
`define REQ_MEM_RD    3'h2
`define REQ_MEM_WR    3'h3
`define REQ_IO_RD     3'h4
`define REQ_IO_WR     3'h5
`define REQ_REFRESH   3'h6
`define REQ_DMA       3'h7
// Status encoding {kind, idle_wait_n, fetch_mark_n}
`define ST_FIRST_FETCH 3'h2
`define ST_NEXT_FETCH  3'h6
`define ST_OTHER       3'h7
`define ST_DMA         3'h1
`define ST_HALT        3'h0
`define ST_SLEEP       3'h5
// Interrupt take codes
`define TAKE_NONE     3'h0
`define TAKE_NMI      3'h1
`define TAKE_MASKABLE_IRQ_0_N     3'h2
`define TAKE_MASKABLE_IRQ_1_N     3'h3
`define TAKE_MASKABLE_IRQ_2_N     3'h4
`endif

// ==== rtl/sync_edge.v ====
// Purpose: Two-flop synchroniser with falling edge pulse, per bit.
// Assumes: Inputs asynchronous to mclk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module sync_edge #(
	parameter W = 1
) (
	input  wire         mclk,
	input  wire         nrst,
	input  wire [W-1:0] async_in,
	input  wire [W-1:0] rst_val,
	output wire [W-1:0] level_out,
	output wire [W-1:0] fall_pulse
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	wire [W-1:0] unused_rst;
	assign unused_rst = rst_val;
	// Idle-high inputs reset to one so no false edge appears at release
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= {W{1'b1}};
			s2_q <= {W{1'b1}};
			s3_q <= {W{1'b1}};
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign level_out  = s2_q;
	assign fall_pulse = s3_q & ~s2_q;
endmodule // sync_edge

// ==== test/cpu_bus_pins_checker.sv ====
// Purpose: Pin properties of the bus sequencer.
// Assumes: Bound to cpu_bus_pins; strobes active low.
// Notes: Reset levels are checked by the bench, as these sleep in reset.
`timescale 1ns/1ps
module cpu_bus_pins_checker #(
	parameter AW = 20
) (
	input logic          mclk,
	input logic          nrst,
	input logic [AW-1:0] addr_oe,
	input logic          data_oe,
	input logic          strobe_oe,
	input logic          memory_cycle_n,
	input logic          io_cycle_n,
	input logic          read_pulse_n,
	input logic          put_pulse_n,
	input logic          fetch_mark_n,
	input logic          refresh_cycle_n,
	input logic          cycle_kind_flag,
	input logic          idle_wait_n,
	input logic          bus_grant_n,
	input logic          bus_claim_n,
	input logic          wait_n,
	input logic          sys_clk
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Steps of a stalled read and of a held claim
	sequence s_rd_start; $fell(read_pulse_n); endsequence
	sequence s_stall; !wait_n [*8]; endsequence
	sequence s_claim; $fell(bus_claim_n) ##1 !bus_claim_n [*7]; endsequence
	a_grant_float: assert property (!bus_grant_n |-> addr_oe == '0 && !data_oe && !strobe_oe)
		else $error("bus driven while granted");
	a_grant_marks: assert property (!bus_grant_n |-> fetch_mark_n && idle_wait_n)
		else $error("marks low while granted");
	a_claim_grant: assert property (s_claim |-> ##[0:60] !bus_grant_n)
		else $error("claim not granted");
	a_wait_hold: assert property (s_rd_start ##0 s_stall |-> !read_pulse_n)
		else $error("read ended during wait");
	a_clk_half: assert property ($past(nrst) |-> sys_clk != $past(sys_clk))
		else $error("system clock not half rate");
	a_fetch_pair: assert property (!fetch_mark_n && idle_wait_n |-> !memory_cycle_n || !io_cycle_n)
		else $error("fetch mark alone");
	a_refresh_mem: assert property (!refresh_cycle_n |-> !memory_cycle_n)
		else $error("refresh without memory cycle");
	a_strobe_excl: assert property (memory_cycle_n || io_cycle_n)
		else $error("memory and io both low");
	a_put_data: assert property (!put_pulse_n |-> data_oe)
		else $error("write strobe without data");
	a_read_float: assert property (!read_pulse_n |-> !data_oe)
		else $error("data driven during read");
	a_status_legal: assert property ({cycle_kind_flag, idle_wait_n, fetch_mark_n} != 3'h4)
		else $error("illegal status code");
endmodule // cpu_bus_pins_checker

bind cpu_bus_pins cpu_bus_pins_checker #(.AW(AW)) chk_u (.*);

// ==== test/mem_peer.sv ====
// Purpose: Memory and I/O device on the far side of the pins.
// Assumes: One byte store keyed by the low address byte.
// Notes: Idle data toggles so a stale bus never reads as valid.
`timescale 1ns/1ps
module mem_peer (
	input  logic       mclk,
	input  logic       slow,
	input  logic [7:0] addr,
	input  logic [7:0] wdata,
	input  logic       memory_cycle_n,
	input  logic       io_cycle_n,
	input  logic       read_pulse_n,
	input  logic       put_pulse_n,
	output logic [7:0] data_i,
	output logic       wait_n
);
	logic [7:0] mem [0:255];
	logic [7:0] junk_q = 8'h00;
	logic [4:0] cnt_q = 5'h00;
	// Drive only while read is low, else a changing pattern
	assign data_i = !read_pulse_n ? mem[addr] : junk_q;
	// Slow mode holds wait low for 16 cycles from the cycle start
	always @(posedge mclk) begin
		junk_q <= ~junk_q;
		if (!put_pulse_n) mem[addr] <= wdata;
		cnt_q <= (memory_cycle_n && io_cycle_n) ? 5'h00 : cnt_q + {4'h0, cnt_q != 5'h1f};
		wait_n <= !(slow && !(memory_cycle_n && io_cycle_n) && cnt_q < 5'h10);
	end
endmodule // mem_peer

// ==== test/cpu_bus_pins_test.sv ====
// Purpose: Self-checking bench for the bus pin sequencer.
// Assumes: Peer answers reads; inputs change on the rising edge.
// Notes: DMA request and timer inputs are driven only in the short pin-level checks after the wait test.
`timescale 1ns/1ps
`include "cpu_pins_map.vh"
module cpu_bus_pins_test;
	typedef struct {logic [2:0] k; logic [19:0] a; logic [7:0] d; logic ff;
		logic [5:0] lo; logic [19:0] m; logic [2:0] s;} row_t;
	logic mclk = 0, nrst = 0, slow = 0, req_first_fetch = 0, req_instr_end = 0;
	logic req_last_dma_ch0 = 0, req_last_dma_ch1 = 0, req_halt = 0, req_sleep = 0;
	logic timer_wave_out = 0, timer_pin_sel = 0, bus_claim_n = 1, nonmaskable_irq_n = 1;
	logic maskable_irq_0_n = 1, maskable_irq_1_n = 1, maskable_irq_2_n = 1;
	logic [1:0] dma_edge_mode = 2'h0, dma_taken = 2'h0, dma_req_n = 2'h3, dma_pending;
	logic [2:0] req_kind = 3'h0, irq_take, st, take;
	logic [19:0] req_addr = 20'h0, irq_vector_addr, addr_o, addr_oe, cap, vec;
	logic [7:0] req_wdata = 8'h0, read_data, data_o, data_i;
	logic [5:0] seen;
	logic req_ready, cycle_done, bus_granted, sys_clk, data_oe, memory_cycle_n, io_cycle_n;
	logic read_pulse_n, put_pulse_n, strobe_oe, fetch_mark_n, refresh_cycle_n, cycle_kind_flag;
	logic idle_wait_n, bus_grant_n, block_done_0_n, block_done_1_n, wait_n;
	int n_fail = 0, n_tests = 0, cyc, fast, i;
	// Rows: kind, address, data, first, strobes seen low, address mask, status
	row_t rows [7] = '{
		'{`REQ_MEM_WR, 20'h12345, 8'ha5, 0, 6'h1b, 20'hfffff, 3'h7},
		'{`REQ_MEM_RD, 20'h12345, 8'ha5, 0, 6'h17, 20'hfffff, 3'h7},
		'{`REQ_IO_WR, 20'h00077, 8'h3c, 0, 6'h2b, 20'h0ffff, 3'h7},
		'{`REQ_IO_RD, 20'h00077, 8'h3c, 0, 6'h27, 20'h0ffff, 3'h7},
		'{`REQ_FETCH, 20'hf0045, 8'ha5, 1, 6'h15, 20'hfffff, `ST_FIRST_FETCH},
		'{`REQ_FETCH, 20'h00145, 8'ha5, 0, 6'h15, 20'hfffff, `ST_NEXT_FETCH},
		'{`REQ_REFRESH, 20'h000ab, 8'h00, 0, 6'h1e, 20'h000ff, 3'h7}};
	cpu_bus_pins dut_u (.*);
	mem_peer peer_u (.mclk(mclk), .slow(slow), .addr(addr_o[7:0]), .wdata(data_o),
		.memory_cycle_n(memory_cycle_n), .io_cycle_n(io_cycle_n), .read_pulse_n(read_pulse_n),
		.put_pulse_n(put_pulse_n), .data_i(data_i), .wait_n(wait_n));
	always #2 mclk = ~mclk;
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// One machine cycle; strobes and status are sampled on settled falling edges
	task automatic issue(input logic [2:0] k, input logic [19:0] a, input logic [7:0] d, input logic ff);
		@(posedge mclk);
		req_kind <= k;
		req_addr <= a;
		req_wdata <= d;
		req_first_fetch <= ff;
		seen = 6'h3f;
		@(negedge mclk);
		for (i = 0; i < 60 && req_ready !== 1'b1; i++) @(negedge mclk);
		@(posedge mclk);
		req_kind <= `REQ_NONE;
		for (cyc = 0; cyc < 300 && cycle_done !== 1'b1; cyc++) begin
			@(negedge mclk);
			seen = seen & {memory_cycle_n, io_cycle_n, read_pulse_n, put_pulse_n, fetch_mark_n, refresh_cycle_n};
			if (!(memory_cycle_n && io_cycle_n)) cap = addr_o;
			if (!(memory_cycle_n && io_cycle_n)) st = {cycle_kind_flag, idle_wait_n, fetch_mark_n};
		end
		take = irq_take;
		vec = irq_vector_addr;
		@(posedge mclk);
	endtask
	task automatic end_sim;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge mclk);
		chk("addr_oe in reset", 20'h0, addr_oe);
		chk("data_oe in reset", 20'h0, data_oe);
		chk("pins in reset", 20'h1ff, {memory_cycle_n, io_cycle_n, read_pulse_n, put_pulse_n,
			fetch_mark_n, refresh_cycle_n, bus_grant_n, cycle_kind_flag, idle_wait_n});
		repeat (2) @(posedge mclk);
		nrst <= 1;
		repeat (4) @(posedge mclk);
		foreach (rows[r]) begin
			issue(rows[r].k, rows[r].a, rows[r].d, rows[r].ff);
			chk("strobes", rows[r].lo, seen);
			chk("address", rows[r].a & rows[r].m, cap & rows[r].m);
			chk("status", rows[r].s, st);
			if (!rows[r].lo[3]) chk("read data", rows[r].d, read_data);
		end
		fast = cyc;
		slow <= 1;
		issue(`REQ_MEM_RD, 20'h12345, 8'h00, 0);
		chk("wait stretch", 1, cyc >= fast + 6);
		chk("stalled read data", 8'ha5, read_data);
		timer_pin_sel <= 1;
		timer_wave_out <= 1;
		dma_req_n <= 2'h2;
		repeat (4) @(negedge mclk);
		chk("timer on a18", 1, addr_o[18]);
		chk("dma level", 2'h1, dma_pending);
		@(posedge mclk);
		timer_pin_sel <= 0;
		dma_edge_mode <= 2'h3;
		dma_req_n <= 2'h3;
		repeat (4) @(negedge mclk);
		chk("dma edge held", 2'h1, dma_pending);
		@(posedge mclk);
		slow <= 0;
		bus_claim_n <= 0;
		for (i = 0; i < 100 && bus_grant_n !== 1'b0; i++) @(negedge mclk);
		chk("grant", 0, bus_grant_n);
		chk("addr float when granted", 0, addr_oe);
		chk("float when granted", 0, {data_oe, strobe_oe});
		chk("marks when granted", 3, {fetch_mark_n, idle_wait_n});
		repeat (8) @(posedge mclk);
		bus_claim_n <= 1;
		for (i = 0; i < 100 && bus_grant_n !== 1'b1; i++) @(negedge mclk);
		chk("grant released", 1, bus_grant_n);
		@(posedge mclk);
		nonmaskable_irq_n <= 0;
		maskable_irq_0_n <= 0;
		maskable_irq_1_n <= 0;
		req_instr_end <= 1;
		issue(`REQ_MEM_RD, 20'h00045, 8'h00, 0);
		chk("nmi first", `TAKE_NMI, take);
		chk("nmi vector", `NMI_VECTOR, vec);
		issue(`REQ_MEM_RD, 20'h00045, 8'h00, 0);
		chk("maskable_irq_0_n over maskable_irq_1_n", `TAKE_MASKABLE_IRQ_0_N, take);
		maskable_irq_0_n <= 1;
		issue(`REQ_MEM_RD, 20'h00045, 8'h00, 0);
		chk("maskable_irq_0_n ack strobes", 6'h2d, seen);
		chk("maskable_irq_1_n last", `TAKE_MASKABLE_IRQ_1_N, take);
		maskable_irq_1_n <= 1;
		req_instr_end <= 0;
		req_halt <= 1;
		issue(`REQ_MEM_RD, 20'h00045, 8'h00, 0);
		repeat (8) @(negedge mclk);
		chk("halt idle", 0, idle_wait_n);
		chk("halt status", `ST_HALT, {cycle_kind_flag, idle_wait_n, fetch_mark_n});
		@(posedge mclk);
		req_halt <= 0;
		maskable_irq_2_n <= 0;
		repeat (8) @(negedge mclk);
		chk("halt woken", 1, idle_wait_n);
		@(posedge mclk);
		maskable_irq_2_n <= 1;
		req_sleep <= 1;
		repeat (12) @(negedge mclk);
		chk("sleep status", `ST_SLEEP, {cycle_kind_flag, idle_wait_n, fetch_mark_n});
		chk("sleep strobes", 20'hf, {memory_cycle_n, io_cycle_n, read_pulse_n, put_pulse_n});
		end_sim();
	end
endmodule // cpu_bus_pins_test
